// File: rtl/tel_trace_event_logic.sv
// event/resource evaluation and trace byte stream with sync and timestamp insertion
// Contract
// - selector holds resource A, B, function fields
// - resource field splits into type and index
// - decode watchpoint inputs and counter at zero
// - decode start/stop, external inputs, constant true
// - combine A and B by function code
// - timestamps are 48-bit unsigned binary
// - fixed sync packet every 1024 output bytes
// - output follows trace bus valid/ready protocol
// - one reduced counter, no other comparators
// - accept four watchpoint match inputs
// - absent comparators never assert
// - start on rise, stop on fall
// - trace only while enable event true; sync and timestamp packets go out regardless
`timescale 1ns/1ps
module tel_trace_event_logic
    import tel_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 rst_b,
    input  wire logic [NUM_WATCH-1:0] wpt_match,
    input  wire logic                 wpt_four_present,
    input  wire logic [NUM_EXT-1:0]   ext_trigger_inputs,
    input  wire logic [NUM_WATCH-1:0] start_sel,
    input  wire logic [NUM_WATCH-1:0] stop_sel,
    input  wire logic [SEL_W-1:0]     trace_enable_event_reg,
    input  wire logic [SEL_W-1:0]     trigger_event_reg,
    input  wire logic                 ctr_load,
    input  wire logic [CTR_W-1:0]     ctr_reload,
    input  wire logic                 ctr_enable,
    input  wire logic [ID_W-1:0]      trace_id,
    input  wire logic [TS_W-1:0]      ts_value,
    input  wire logic                 ts_req,
    input  wire logic                 in_valid,
    output logic                      in_ready,
    input  wire logic [7:0]           in_data,
    output logic                      atvalid,
    input  wire logic                 atready,
    output logic [7:0]                atdata,
    output logic [ID_W-1:0]           atid,
    output logic                      trace_active,
    output logic                      trigger_out,
    output logic                      start_state
);
    // ------------------------------------------------------------
    // resource decode and event evaluation
    // ------------------------------------------------------------
    function automatic logic res_val(input logic [RES_W-1:0] r, input logic [3:0] w,
                                     input logic c0, input logic ss, input logic [1:0] x);
        logic [RTYPE_W-1:0] t;
        logic [RIDX_W-1:0]  i;
        t = r[RTYPE_LSB +: RTYPE_W];
        i = r[RIDX_W-1:0];
        res_val = 1'b0;
        if (t == RT_WATCH && i <= IDX_WATCH_MAX) res_val = w[i[1:0]];
        else if (t == RT_COUNTER && i == 4'h0) res_val = c0;
        else if (t == RT_STARTSTOP && i == IDX_SPECIAL) res_val = ss;
        else if (t == RT_EXT && i <= IDX_EXT_MAX) res_val = x[i[0]];
        else if (t == RT_EXT && i == IDX_SPECIAL) res_val = 1'b1;
    endfunction

    function automatic logic evt_eval(input logic [SEL_W-1:0] s, input logic [3:0] w,
                                      input logic c0, input logic ss, input logic [1:0] x);
        logic a;
        logic b;
        a = res_val(s[RES_A_LSB +: RES_W], w, c0, ss, x);
        b = res_val(s[RES_B_LSB +: RES_W], w, c0, ss, x);
        unique case (s[FUNC_LSB +: FUNC_W])
            FN_A:         evt_eval = a;
            FN_NA:        evt_eval = !a;
            FN_A_AND_B:   evt_eval = a & b;
            FN_NA_AND_B:  evt_eval = !a & b;
            FN_NA_AND_NB: evt_eval = !a & !b;
            FN_A_OR_B:    evt_eval = a | b;
            FN_NA_OR_B:   evt_eval = !a | b;
            FN_NA_OR_NB:  evt_eval = !a | !b;
        endcase
    endfunction

    logic [NUM_EXT-1:0]   ext_s1_r, ext_s2_r, ext_s3_r, ext_r, ext_nxt;
    logic [NUM_WATCH-1:0] wpt_prev_r, wpt_eff;
    logic [CTR_W-1:0]     ctr_r, ctr_nxt;
    logic                 ss_r, ss_nxt, te_r, te_nxt, trg_r, trg_nxt, trgp_r, trgp_nxt;
    logic                 te_evt, trg_evt;

    always_comb begin
        // missing comparators tie low so selectors on them never fire
        wpt_eff = wpt_match & (wpt_four_present ? WMASK_FOUR : WMASK_ONE);
        ext_nxt = ext_r;
        for (int k = 0; k < NUM_EXT; k++) begin
            if (ext_s2_r[k] == ext_s3_r[k]) ext_nxt[k] = ext_s3_r[k];
        end
        ss_nxt = ss_r;
        if (|(stop_sel & wpt_prev_r & ~wpt_eff)) ss_nxt = 1'b0;
        if (|(start_sel & ~wpt_prev_r & wpt_eff)) ss_nxt = 1'b1;
        // single reduced counter: reload and count down, no sequencer
        ctr_nxt = ctr_r;
        if (ctr_load) ctr_nxt = ctr_reload;
        else if (ctr_enable && ctr_r != '0) ctr_nxt = ctr_r - 16'h0001;
        te_evt  = evt_eval(trace_enable_event_reg, wpt_eff, ctr_r == '0, ss_r, ext_r);
        trg_evt = evt_eval(trigger_event_reg, wpt_eff, ctr_r == '0, ss_r, ext_r);
        te_nxt   = te_evt;
        trg_nxt  = trg_evt;
        trgp_nxt = trg_evt & !trg_r;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ext_s1_r   <= '0;
            ext_s2_r   <= '0;
            ext_s3_r   <= '0;
            ext_r      <= '0;
            wpt_prev_r <= '0;
            ctr_r      <= '0;
            ss_r       <= 1'b0;
            te_r       <= 1'b0;
            trg_r      <= 1'b0;
            trgp_r     <= 1'b0;
        end else begin
            ext_s1_r   <= ext_trigger_inputs;
            ext_s2_r   <= ext_s1_r;
            ext_s3_r   <= ext_s2_r;
            ext_r      <= ext_nxt;
            wpt_prev_r <= wpt_eff;
            ctr_r      <= ctr_nxt;
            ss_r       <= ss_nxt;
            te_r       <= te_nxt;
            trg_r      <= trg_nxt;
            trgp_r     <= trgp_nxt;
        end
    end

    assign trace_active = te_r;
    assign trigger_out  = trgp_r;
    assign start_state  = ss_r;

    // ------------------------------------------------------------
    // byte generator: data, sync and timestamp packets
    // ------------------------------------------------------------
    tel_state_e        st_r, st_nxt;
    logic [3:0]        idx_r, idx_nxt;
    logic [BCNT_W-1:0] bcnt_r, bcnt_nxt;
    logic              syncp_r, syncp_nxt, tsp_r, tsp_nxt;
    logic [TS_W-1:0]   tsreq_r, tsreq_nxt, tsout_r, tsout_nxt;
    logic              gen_valid, push, buf_ready;
    logic [7:0]        gen_data;

    always_comb begin
        st_nxt    = st_r;
        idx_nxt   = idx_r;
        tsout_nxt = tsout_r;
        gen_valid = 1'b0;
        gen_data  = SYNC_FILL;
        in_ready  = !te_r;
        unique case (st_r)
            ST_DATA: begin
                if (syncp_r) begin
                    st_nxt  = ST_SYNC;
                    idx_nxt = 4'h0;
                end else if (tsp_r) begin
                    st_nxt    = ST_TS;
                    idx_nxt   = 4'h0;
                    tsout_nxt = tsreq_r;
                end else begin
                    gen_valid = in_valid & te_r;
                    gen_data  = in_data;
                    in_ready  = !te_r || buf_ready;
                end
            end
            ST_SYNC: begin
                gen_valid = 1'b1;
                gen_data  = (idx_r == SYNC_LEN - 4'h1) ? SYNC_TAIL : SYNC_FILL;
            end
            ST_TS: begin
                gen_valid = 1'b1;
                // low byte of the 48-bit count goes first
                gen_data  = (idx_r == 4'h0) ? TS_HDR : tsout_r[8*(idx_r-4'h1) +: 8];
            end
        endcase
        push = gen_valid & buf_ready;
        if (push && st_r != ST_DATA) begin
            idx_nxt = idx_r + 4'h1;
            if ((st_r == ST_SYNC && idx_r == SYNC_LEN - 4'h1) ||
                (st_r == ST_TS && idx_r == TS_LEN - 4'h1)) st_nxt = ST_DATA;
        end
        bcnt_nxt  = push ? bcnt_r + 10'h001 : bcnt_r;
        // a new request in the clearing cycle is kept
        syncp_nxt = (push && bcnt_r == BCNT_LAST) | (syncp_r & (st_r != ST_DATA));
        tsp_nxt   = ts_req | (tsp_r & !(st_r == ST_DATA && !syncp_r));
        tsreq_nxt = ts_req ? ts_value : tsreq_r;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_r    <= ST_DATA;
            idx_r   <= 4'h0;
            bcnt_r  <= '0;
            syncp_r <= 1'b0;
            tsp_r   <= 1'b0;
            tsreq_r <= '0;
            tsout_r <= '0;
        end else begin
            st_r    <= st_nxt;
            idx_r   <= idx_nxt;
            bcnt_r  <= bcnt_nxt;
            syncp_r <= syncp_nxt;
            tsp_r   <= tsp_nxt;
            tsreq_r <= tsreq_nxt;
            tsout_r <= tsout_nxt;
        end
    end

    // ------------------------------------------------------------
    // two-entry output buffer toward the trace bus
    // ------------------------------------------------------------
    logic [7:0]      buf_r [2];
    logic [7:0]      buf_nxt [2];
    logic            wp_r, wp_nxt, rp_r, rp_nxt;
    logic [1:0]      cnt_r, cnt_nxt;
    logic [ID_W-1:0] id_r;
    logic            pop;

    always_comb begin
        buf_ready = (cnt_r != 2'h2);
        pop       = (cnt_r != 2'h0) & atready;
        buf_nxt   = buf_r;
        wp_nxt    = wp_r;
        rp_nxt    = rp_r;
        if (push) begin
            buf_nxt[wp_r] = gen_data;
            wp_nxt = !wp_r;
        end
        if (pop) rp_nxt = !rp_r;
        cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            buf_r[0] <= 8'h00;
            buf_r[1] <= 8'h00;
            wp_r     <= 1'b0;
            rp_r     <= 1'b0;
            cnt_r    <= 2'h0;
            id_r     <= '0;
        end else begin
            buf_r    <= buf_nxt;
            wp_r     <= wp_nxt;
            rp_r     <= rp_nxt;
            cnt_r    <= cnt_nxt;
            id_r     <= trace_id;
        end
    end

    assign atvalid = (cnt_r != 2'h0);
    assign atdata  = buf_r[rp_r];
    assign atid    = id_r;
endmodule // tel_trace_event_logic

// File: rtl/tel_pkg.sv
// constants and types for the trace event and resource logic
package tel_pkg;
    // ------------------------------------------------------------
    // event selector layout
    // ------------------------------------------------------------
    localparam int SEL_W       = 17;
    localparam int RES_A_LSB   = 0;
    localparam int RES_B_LSB   = 7;
    localparam int RES_W       = 7;
    localparam int FUNC_LSB    = 14;
    localparam int FUNC_W      = 3;
    localparam int RTYPE_LSB   = 4;
    localparam int RTYPE_W     = 3;
    localparam int RIDX_W      = 4;
    // ------------------------------------------------------------
    // resource types and indices
    // ------------------------------------------------------------
    localparam logic [2:0] RT_WATCH   = 3'h2;
    localparam logic [2:0] RT_COUNTER = 3'h4;
    localparam logic [2:0] RT_STARTSTOP = 3'h5;
    localparam logic [2:0] RT_EXT     = 3'h6;
    localparam logic [3:0] IDX_WATCH_MAX = 4'h3;
    localparam logic [3:0] IDX_EXT_MAX = 4'h1;
    localparam logic [3:0] IDX_SPECIAL = 4'hf;
    localparam logic [16:0] SEL_ALWAYS_TRUE = 17'h0006f;
    // ------------------------------------------------------------
    // boolean function codes
    // ------------------------------------------------------------
    localparam logic [2:0] FN_A        = 3'h0;
    localparam logic [2:0] FN_NA       = 3'h1;
    localparam logic [2:0] FN_A_AND_B  = 3'h2;
    localparam logic [2:0] FN_NA_AND_B = 3'h3;
    localparam logic [2:0] FN_NA_AND_NB = 3'h4;
    localparam logic [2:0] FN_A_OR_B   = 3'h5;
    localparam logic [2:0] FN_NA_OR_B  = 3'h6;
    localparam logic [2:0] FN_NA_OR_NB = 3'h7;
    // ------------------------------------------------------------
    // stream and sizes
    // ------------------------------------------------------------
    localparam int NUM_WATCH   = 4;
    localparam int NUM_EXT     = 2;
    localparam int CTR_W       = 16;
    localparam int TS_W        = 48;
    localparam int TS_BYTES    = 6;
    localparam int ID_W        = 7;
    localparam int SYNC_PERIOD = 1024;
    localparam int BCNT_W      = 10;
    localparam logic [9:0] BCNT_LAST = 10'h3ff;
    localparam logic [3:0] SYNC_LEN  = 4'h6;
    localparam logic [7:0] SYNC_FILL = 8'h00;
    localparam logic [7:0] SYNC_TAIL = 8'h80;
    // arbitrary header code for the timestamp packet
    localparam logic [7:0] TS_HDR    = 8'h42;
    localparam logic [3:0] TS_LEN    = 4'h7;
    localparam logic [3:0] WMASK_ONE  = 4'h1;
    localparam logic [3:0] WMASK_FOUR = 4'hf;

    typedef enum logic [1:0] {
        ST_DATA = 2'b00,
        ST_SYNC = 2'b01,
        ST_TS   = 2'b10
    } tel_state_e;
endpackage

// File: tb/tel_sink.sv
// trace sink model for the byte stream
`timescale 1ns/1ps
module tel_sink (
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire logic       slow,
    input  wire logic       stall,
    input  wire logic       atvalid,
    input  wire logic [7:0] atdata,
    output logic            atready
);
    logic [7:0] got[$];
    logic       tick_r;
    // slow mode takes every other cycle to squeeze the buffer
    assign atready = !stall && !(slow && tick_r);
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= !tick_r;
            if (atvalid && atready) got.push_back(atdata);
        end
    end
endmodule // tel_sink

// File: tb/tel_chk_sva.sv
// port assertions for the trace event logic
`timescale 1ns/1ps
module tel_chk
    import tel_pkg::*;
(
    input wire logic             mclk,
    input wire logic             rst_b,
    input wire logic [3:0]       wpt_match,
    input wire logic             wpt_four_present,
    input wire logic [3:0]       start_sel,
    input wire logic [3:0]       stop_sel,
    input wire logic [SEL_W-1:0] trace_enable_event_reg,
    input wire logic [ID_W-1:0]  trace_id,
    input wire logic             in_ready,
    input wire logic             atvalid,
    input wire logic             atready,
    input wire logic [7:0]       atdata,
    input wire logic [ID_W-1:0]  atid,
    input wire logic             trace_active,
    input wire logic             start_state
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    logic [3:0] wm;
    // absent comparators must not reach the start/stop logic
    assign wm = wpt_four_present ? WMASK_FOUR : WMASK_ONE;
    a_const_true: assert property (
        trace_enable_event_reg == SEL_ALWAYS_TRUE |=> trace_active)
        else $error("constant true ignored");
    a_watch_follow: assert property (
        trace_enable_event_reg == 17'h00020 |=> trace_active == $past(wpt_match[0]))
        else $error("watch event wrong");
    a_absent_low: assert property (
        !wpt_four_present && trace_enable_event_reg == 17'h00021 |=> !trace_active)
        else $error("absent comparator fired");
    a_start_rise: assert property (
        $past(rst_b) && |(start_sel & wm & wpt_match & ~$past(wpt_match)) |=> start_state)
        else $error("start missed");
    a_stop_fall: assert property (
        $past(rst_b) && |(stop_sel & wm & ~wpt_match & $past(wpt_match))
        && !(|(start_sel & wm & wpt_match & ~$past(wpt_match))) |=> !start_state)
        else $error("stop missed");
    a_idle_drop: assert property (!trace_active |-> in_ready)
        else $error("input stalled while idle");
    a_out_hold: assert property (atvalid && !atready |=> atvalid && $stable(atdata))
        else $error("output changed before accept");
    a_id_follow: assert property ($stable(trace_id) |=> atid == $past(trace_id))
        else $error("trace id not carried");
    c_start: cover property ($rose(start_state));
    c_sync: cover property (atvalid && atready && atdata == SYNC_TAIL);
    c_active: cover property ($rose(trace_active));
endmodule // tel_chk
bind tel_trace_event_logic tel_chk u_chk (.mclk(mclk), .rst_b(rst_b), .wpt_match(wpt_match),
    .wpt_four_present(wpt_four_present), .start_sel(start_sel), .stop_sel(stop_sel),
    .trace_enable_event_reg(trace_enable_event_reg), .trace_id(trace_id), .in_ready(in_ready),
    .atvalid(atvalid), .atready(atready), .atdata(atdata), .atid(atid),
    .trace_active(trace_active), .start_state(start_state));

// File: tb/tel_trace_event_logic_tb.sv
// self-checking bench for the trace event logic
`timescale 1ns/1ps
module tel_trace_event_logic_tb import tel_pkg::*; ;
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
    logic             mclk = 1'b0, rst_b = 1'b0, four = 1'b1, ld = 1'b0, en = 1'b0;
    logic             ts_req = 1'b0, in_valid = 1'b0, slow = 1'b0, stall = 1'b0;
    logic [3:0]       wpt = 4'h0, ssel = 4'h0, psel = 4'h0;
    logic [1:0]       ext = 2'h0;
    logic [SEL_W-1:0] te = 17'h00000, tg = 17'h00020;
    logic [15:0]      reload = 16'h0000;
    logic [47:0]      tsv = 48'h0123456789ab;
    logic [7:0]       in_data = 8'h00, atdata;
    logic [6:0]       tid = 7'h15, atid;
    logic             in_ready, atvalid, atready, act, trig, sst;
    int               err_total = 0, checks = 0, cyc = 0, n, base;
    tel_trace_event_logic uut (.mclk(mclk), .rst_b(rst_b), .wpt_match(wpt),
        .wpt_four_present(four), .ext_trigger_inputs(ext), .start_sel(ssel),
        .stop_sel(psel), .trace_enable_event_reg(te), .trigger_event_reg(tg),
        .ctr_load(ld), .ctr_reload(reload), .ctr_enable(en), .trace_id(tid),
        .ts_value(tsv), .ts_req(ts_req), .in_valid(in_valid), .in_ready(in_ready),
        .in_data(in_data), .atvalid(atvalid), .atready(atready), .atdata(atdata),
        .atid(atid), .trace_active(act), .trigger_out(trig), .start_state(sst));
    tel_sink sink (.mclk(mclk), .rst_b(rst_b), .slow(slow), .stall(stall),
        .atvalid(atvalid), .atdata(atdata), .atready(atready));
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end
    function automatic logic fn(input logic [2:0] f, input logic a, input logic b);
        logic [7:0] t;
        t = {!a || !b, !a || b, a || b, !a && !b, !a && b, a && b, !a, a};
        return t[f];
    endfunction
    task automatic step(input int k);
        repeat (k) @(negedge mclk);
    endtask
    task automatic feed();
        logic acc;
        acc = in_ready;
        step(1);
        if (acc === 1'b1) begin
            n++;
            in_data = (n == 1024) ? 8'h55 : n[7:0];
        end
    endtask
    task automatic t_events();
        for (int i = 0; i < 32; i++) begin
            te = {i[4:2], 7'h21, 7'h20};
            wpt = {2'b00, i[1:0]};
            step(1);
            `CHK("function", fn(i[4:2], i[0], i[1]), act)
        end
        for (int i = 0; i < 6; i++) begin
            te = {FN_A, 7'h00, 3'h6, 4'(i % 3)};
            ext = (i < 3) ? 2'b01 : 2'b10;
            step(5);
            `CHK("ext", (i % 3) == (i / 3), act)
        end
        n = 0;
        te = 17'h00020;
        wpt = 4'h0;
        step(2);
        `CHK("watch low", 0, act)
        wpt = 4'h1;
        repeat (6) begin
            step(1);
            n += int'(trig === 1'b1);
        end
        `CHK("trigger", 1, n)
        `CHK("watch high", 1, act)
    endtask
    task automatic t_counter();
        te = {FN_A, 7'h00, 7'h40};
        reload = 16'h0003;
        ld = 1'b1;
        step(1);
        ld = 1'b0;
        step(1);
        `CHK("ctr loaded", 0, act)
        en = 1'b1;
        step(3);
        `CHK("ctr counting", 0, act)
        step(1);
        `CHK("ctr zero", 1, act)
    endtask
    task automatic t_startstop();
        te = 17'h0005f;
        ssel = 4'h1;
        psel = 4'h2;
        wpt = 4'h0;
        step(1);
        wpt = 4'h1;
        step(1);
        `CHK("start", 1, sst)
        wpt = 4'h2;
        step(1);
        `CHK("ss resource", 1, act)
        wpt = 4'h0;
        step(1);
        `CHK("stop", 0, sst)
        four = 1'b0;
        te = 17'h00021;
        wpt = 4'he;
        step(2);
        `CHK("absent", 0, act)
        four = 1'b1;
        step(2);
        `CHK("present", 1, act)
    endtask
    task automatic t_stream();
        logic [7:0] exp_b;
        te = SEL_ALWAYS_TRUE;
        stall = 1'b1;
        n = 0;
        in_valid = 1'b1;
        in_data = 8'h00;
        repeat (6) feed();
        `CHK("depth", 2, n)
        stall = 1'b0;
        slow = 1'b1;
        while (n < 1025) feed();
        in_valid = 1'b0;
        for (int i = 0; i < 99 && sink.got.size() < 1031; i++) step(1);
        for (int i = 0; i < 1031; i++) begin
            exp_b = (i < 1024) ? i[7:0] : (i < 1029) ? SYNC_FILL : (i == 1029) ? SYNC_TAIL : 8'h55;
            `CHK("stream", exp_b, sink.got[i])
        end
        `CHK("id", tid, atid)
        base = sink.got.size();
        ts_req = 1'b1;
        step(1);
        ts_req = 1'b0;
        in_valid = 1'b1;
        in_data = 8'h77;
        for (int i = 0; i < 50 && in_ready !== 1'b1; i++) step(1);
        step(1);
        in_valid = 1'b0;
        for (int i = 0; i < 50 && sink.got.size() < base + 8; i++) step(1);
        for (int i = 0; i < 8; i++) begin
            exp_b = (i == 0) ? TS_HDR : (i == 7) ? 8'h77 : tsv[8*(i-1) +: 8];
            `CHK("stamp", exp_b, sink.got[base+i])
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        step(2);
        rst_b = 1'b1;
        t_counter();
        t_events();
        t_startstop();
        t_stream();
        report_and_stop();
    end
endmodule // tel_trace_event_logic_tb
